// ### asr_pkg.sv
// constants, register map and shared types of the asynchronous serial receiver
`default_nettype none
package asr_pkg;
    // ============================================================
    // register indices (byte address is four times the index)
    localparam logic [9:0] REG_INTERRUPT_CONTROL = 10'h00b;
    localparam logic [9:0] REG_PERIPHERAL_FLAGS = 10'h00c;
    localparam logic [9:0] REG_RECEIVE_STATUS_CONTROL = 10'h018;
    localparam logic [9:0] REG_RECEIVE_DATA_FIFO = 10'h01a;
    localparam logic [9:0] REG_PERIPHERAL_IRQ_ENABLES = 10'h08c;
    localparam logic [9:0] REG_TRANSMIT_STATUS_CONTROL = 10'h098;
    localparam logic [9:0] REG_BAUD_DIVISOR = 10'h099;
    // ============================================================
    // field positions
    localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
    localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
    localparam int RECEIVE_FLAG_BIT = 5;
    localparam int RECEIVE_IRQ_ENABLE_BIT = 5;
    localparam int SERIAL_PORT_ENABLE_BIT = 7;
    localparam int NINE_BIT_RECEIVE_BIT = 6;
    localparam int SINGLE_RECEIVE_ENABLE_BIT = 5;
    localparam int CONTINUOUS_RECEIVE_ENABLE_BIT = 4;
    localparam int ADDRESS_DETECT_ENABLE_BIT = 3;
    localparam int FRAMING_ERROR_BIT = 2;
    localparam int OVERRUN_ERROR_BIT = 1;
    localparam int RECEIVED_NINTH_BIT_BIT = 0;
    localparam int CLOCKED_MODE_SELECT_BIT = 4;
    localparam int HIGH_SPEED_BAUD_BIT = 2;
    // ============================================================
    // reset values and masks
    localparam logic [7:0] INTERRUPT_CONTROL_RESET = 8'h00;
    localparam logic [7:0] PERIPHERAL_IRQ_ENABLES_RESET = 8'h00;
    localparam logic [7:0] TRANSMIT_STATUS_CONTROL_RESET = 8'h02;
    localparam logic [7:0] TRANSMIT_STATUS_WRITE_MASK = 8'hf5;
    localparam logic [7:0] TRANSMIT_SHIFTER_EMPTY = 8'h02;
    localparam logic [7:0] BAUD_DIVISOR_RESET = 8'h00;
    // ============================================================
    // sampling counts and bus response codes
    localparam int OVERSAMPLE = 16;
    localparam logic [3:0] START_MID_TICK = 4'h7;
    localparam logic [3:0] LAST_TICK = 4'hf;
    localparam logic [1:0] LOW_SPEED_PRESCALE_LAST = 2'h3;
    localparam logic [3:0] LAST_BIT_EIGHT = 4'h7;
    localparam logic [3:0] LAST_BIT_NINE = 4'h8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ============================================================
    // types
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} asr_rx_state_t;
    typedef struct packed {
        logic framing_error;
        logic bit9;
        logic [7:0] data;
    } asr_entry_t;
endpackage : asr_pkg
`default_nettype wire

// ### asr_frame_if.sv
// interface carrying a finished frame from the shifter to the register side
`default_nettype none
interface asr_frame_if;
    import asr_pkg::*;
    logic done;
    asr_entry_t word;
    // ============================================================
    // shifter drives, register side reads
    modport src (output done, output word);
    modport dst (input done, input word);
endinterface : asr_frame_if
`default_nettype wire

// ### asr_baud_gen.sv
// baud generator giving a sixteen-times-bit-rate sampling enable
`default_nettype none
module asr_baud_gen import asr_pkg::*; #(
    parameter int DIV_W = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic run,
    input wire logic [DIV_W-1:0] divisor,
    input wire logic high_speed,
    // sampling enable
    output logic os_tick
);
    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic [1:0] pre;
        logic tick;
    } asr_brg_t;
    asr_brg_t s_r;
    asr_brg_t s_nxt;
    // ============================================================
    // divide by divisor+1, then by four when the slow rate is chosen
    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (!run) begin
            s_nxt.cnt = '0;  // generator held in reset while idle
            s_nxt.pre = '0;
        end else if (s_r.cnt == '0) begin
            s_nxt.cnt = divisor;
            if (high_speed) begin
                s_nxt.tick = 1'b1;
            end else begin
                s_nxt.pre = 2'(s_r.pre + 2'h1);
                s_nxt.tick = (s_r.pre == LOW_SPEED_PRESCALE_LAST);
            end
        end else begin
            s_nxt.cnt = DIV_W'(s_r.cnt - 1'b1);
        end
    end
    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) s_r <= '0;
        else s_r <= s_nxt;
    end
    assign os_tick = s_r.tick;
endmodule : asr_baud_gen
`default_nettype wire

// ### asr_rx_shifter.sv
// data recovery and receive shift register for one asynchronous frame
`default_nettype none
module asr_rx_shifter import asr_pkg::*; (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic run,
    input wire logic os_tick,
    input wire logic nine_bit,
    // serial line
    input wire logic rx_line,
    // finished frame
    asr_frame_if.src fo
);
    typedef struct packed {
        asr_rx_state_t st;
        logic [3:0] tcnt;
        logic [3:0] bitn;
        logic [8:0] receive_shift_register;
        logic done;
        asr_entry_t word;
    } asr_shf_t;
    asr_shf_t s_r;
    asr_shf_t s_nxt;
    // ============================================================
    // frame walk: start check at mid-bit, then one sample per 16 ticks
    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        if (!run) begin
            s_nxt.st = RX_IDLE;
            s_nxt.tcnt = '0;
        end else if (os_tick) begin
            unique case (s_r.st)
                RX_IDLE: begin
                    if (!rx_line) begin
                        s_nxt.st = RX_START;
                        s_nxt.tcnt = '0;
                    end
                end
                RX_START: begin
                    s_nxt.tcnt = 4'(s_r.tcnt + 4'h1);
                    if (s_r.tcnt == START_MID_TICK) begin
                        s_nxt.tcnt = '0;
                        s_nxt.bitn = '0;
                        s_nxt.st = rx_line ? RX_IDLE : RX_DATA;  // glitch rejected
                    end
                end
                RX_DATA: begin
                    s_nxt.tcnt = 4'(s_r.tcnt + 4'h1);
                    if (s_r.tcnt == LAST_TICK) begin
                        // lsb first into the top of the register
                        s_nxt.receive_shift_register = {rx_line, s_r.receive_shift_register[8:1]};
                        s_nxt.bitn = 4'(s_r.bitn + 4'h1);
                        if (s_r.bitn == (nine_bit ? LAST_BIT_NINE : LAST_BIT_EIGHT)) begin
                            s_nxt.st = RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    s_nxt.tcnt = 4'(s_r.tcnt + 4'h1);
                    if (s_r.tcnt == LAST_TICK) begin
                        s_nxt.done = 1'b1;
                        s_nxt.word.framing_error = !rx_line;
                        s_nxt.word.bit9 = nine_bit & s_r.receive_shift_register[8];
                        s_nxt.word.data = nine_bit ? s_r.receive_shift_register[7:0]
                                                   : s_r.receive_shift_register[8:1];
                        s_nxt.st = RX_IDLE;
                    end
                end
            endcase
        end
    end
    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) s_r <= '0;
        else s_r <= s_nxt;
    end
    assign fo.done = s_r.done;
    assign fo.word = s_r.word;
    // ============================================================
    // checks
    property p_stop_framing_error;
        @(posedge aclk) disable iff (!aresetn)
        s_r.done |-> (s_r.word.framing_error == !$past(rx_line));
    endproperty
    a_stop_framing_error: assert property (p_stop_framing_error) else $error("framing error mismatch");
    property p_no_frame_idle;
        @(posedge aclk) disable iff (!aresetn)
        !run |=> !s_r.done;
    endproperty
    a_no_frame_idle: assert property (p_no_frame_idle) else $error("frame while off");
endmodule : asr_rx_shifter
`default_nettype wire

// ### asr_receiver.sv
// asynchronous serial receiver with AXI4-Lite register access
// Functional notes
// - frame is start, eight or nine data bits lsb first, one stop, no parity
// - receives only with clocked-mode select clear, same rate and format as sender
// - one bit lasts 16 or 64 times divisor+1 clocks, 16 with high_speed_baud set
// - data recovery samples the receive line at sixteen times the baud rate
// - frames are accepted only while continuous_receive_enable is set
// - after the stop bit the shift register word moves into the FIFO if room
// - a word moved into the FIFO sets receive_flag, bit 5 of peripheral_flags
// - receive interrupt requires receive_irq_enable, bit 5 of peripheral_irq_enables
// - receive_flag is read-only and clears when the FIFO is read empty
// - data FIFO holds two words, read back in arrival order
// - FIFO full at a third stop bit sets overrun_error and drops the word
// - overrun_error clears only while continuous_receive_enable is clear
// - while overrun_error is set no word enters the FIFO
// - framing_error is set when the stop bit is sampled low
// - framing_error and ninth bit travel with each entry; reads advance them
// - without address detect every word is loaded and flagged
// - reception halts while the device sleeps
`default_nettype none
module asr_receiver import asr_pkg::*; #(
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // serial line and power state
    input wire logic rx_line,
    input wire logic sleep_mode,
    // interrupt request
    output logic rx_irq
);
    localparam int CNT_W = $clog2(DEPTH + 1);
    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_have;
        logic [9:0] aw_idx;
        logic w_have;
        logic w_en;
        logic [7:0] w_data;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic [7:0] interrupt_control;
        logic [7:0] peripheral_irq_enables;
        logic [7:0] transmit_status_control;
        logic [7:0] baud_divisor;
        logic serial_port_enable;
        logic nine_bit_receive;
        logic single_receive_enable;
        logic continuous_receive_enable;
        logic address_detect_enable;
        logic overrun_error;
        logic receive_flag;
        logic irq;
        logic [CNT_W-1:0] count;
        asr_entry_t [DEPTH-1:0] fifo;
    } asr_top_t;
    asr_top_t s_r;
    asr_top_t s_nxt;
    logic rx_en;
    logic accept;
    logic push;
    logic pop;
    logic overrun;
    logic [CNT_W-1:0] widx;
    logic os_tick;
    asr_frame_if fr ();

    // ============================================================
    // register map decode shared by read and write
    function automatic logic reg_known(input logic [9:0] idx);
        reg_known = (idx == REG_INTERRUPT_CONTROL) || (idx == REG_PERIPHERAL_FLAGS)
                 || (idx == REG_RECEIVE_STATUS_CONTROL) || (idx == REG_RECEIVE_DATA_FIFO)
                 || (idx == REG_PERIPHERAL_IRQ_ENABLES) || (idx == REG_TRANSMIT_STATUS_CONTROL)
                 || (idx == REG_BAUD_DIVISOR);
    endfunction : reg_known

    // ============================================================
    // sub-blocks
    asr_baud_gen #(.DIV_W(8)) u_brg (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(rx_en),
        .divisor(s_r.baud_divisor),
        .high_speed(s_r.transmit_status_control[HIGH_SPEED_BAUD_BIT]),
        .os_tick(os_tick)
    );
    asr_rx_shifter u_shf (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(rx_en),
        .os_tick(os_tick),
        .nine_bit(s_r.nine_bit_receive),
        .rx_line(rx_line),
        .fo(fr)
    );

    // ============================================================
    // next state: bus slave, register file and receive FIFO
    always_comb begin
        s_nxt = s_r;
        // receiver runs only enabled, asynchronous and awake
        rx_en = s_r.serial_port_enable & s_r.continuous_receive_enable
              & !s_r.transmit_status_control[CLOCKED_MODE_SELECT_BIT] & !sleep_mode;
        // address filter
        accept = fr.done & (!(s_r.nine_bit_receive & s_r.address_detect_enable)
                            | fr.word.bit9);
        pop = 1'b0;
        // write channels taken independently, in either order
        if (s_axi_awvalid && s_r.awready) begin
            s_nxt.aw_have = 1'b1;
            s_nxt.aw_idx = s_axi_awaddr[11:2];
        end
        if (s_axi_wvalid && s_r.wready) begin
            s_nxt.w_have = 1'b1;
            s_nxt.w_data = s_axi_wdata[7:0];
            s_nxt.w_en = s_axi_wstrb[0];
        end
        if (s_r.bvalid && s_axi_bready) s_nxt.bvalid = 1'b0;
        // perform the write once both halves are held
        if (s_r.aw_have && s_r.w_have) begin
            s_nxt.aw_have = 1'b0;
            s_nxt.w_have = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = reg_known(s_r.aw_idx) ? RESP_OKAY : RESP_SLVERR;
            if (s_r.w_en) begin
                unique case (s_r.aw_idx)
                    REG_INTERRUPT_CONTROL: s_nxt.interrupt_control = s_r.w_data;
                    REG_PERIPHERAL_IRQ_ENABLES: s_nxt.peripheral_irq_enables = s_r.w_data;
                    REG_BAUD_DIVISOR: s_nxt.baud_divisor = s_r.w_data;
                    REG_TRANSMIT_STATUS_CONTROL: begin
                        s_nxt.transmit_status_control =
                            (s_r.w_data & TRANSMIT_STATUS_WRITE_MASK) | TRANSMIT_SHIFTER_EMPTY;
                    end
                    REG_RECEIVE_STATUS_CONTROL: begin
                        s_nxt.serial_port_enable = s_r.w_data[SERIAL_PORT_ENABLE_BIT];
                        s_nxt.nine_bit_receive = s_r.w_data[NINE_BIT_RECEIVE_BIT];
                        s_nxt.single_receive_enable = s_r.w_data[SINGLE_RECEIVE_ENABLE_BIT];
                        s_nxt.continuous_receive_enable =
                            s_r.w_data[CONTINUOUS_RECEIVE_ENABLE_BIT];
                        s_nxt.address_detect_enable = s_r.w_data[ADDRESS_DETECT_ENABLE_BIT];
                    end
                    default: begin
                        s_nxt.baud_divisor = s_r.baud_divisor;  // read-only or unmapped
                    end
                endcase
            end
        end
        s_nxt.awready = !s_nxt.aw_have && !s_nxt.bvalid;
        s_nxt.wready = !s_nxt.w_have && !s_nxt.bvalid;
        // read: one outstanding, data captured at address acceptance
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
            s_nxt.arready = 1'b1;
        end
        if (s_axi_arvalid && s_r.arready) begin
            s_nxt.arready = 1'b0;
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = reg_known(s_axi_araddr[11:2]) ? RESP_OKAY : RESP_SLVERR;
            s_nxt.rdata = 8'h00;
            unique case (s_axi_araddr[11:2])
                REG_INTERRUPT_CONTROL: s_nxt.rdata = s_r.interrupt_control;
                REG_PERIPHERAL_FLAGS: s_nxt.rdata[RECEIVE_FLAG_BIT] = s_r.receive_flag;
                REG_PERIPHERAL_IRQ_ENABLES: s_nxt.rdata = s_r.peripheral_irq_enables;
                REG_TRANSMIT_STATUS_CONTROL: s_nxt.rdata = s_r.transmit_status_control;
                REG_BAUD_DIVISOR: s_nxt.rdata = s_r.baud_divisor;
                REG_RECEIVE_STATUS_CONTROL: begin
                    // status of the oldest entry
                    s_nxt.rdata = {s_r.serial_port_enable, s_r.nine_bit_receive,
                                   s_r.single_receive_enable, s_r.continuous_receive_enable,
                                   s_r.address_detect_enable, s_r.fifo[0].framing_error,
                                   s_r.overrun_error, s_r.fifo[0].bit9};
                end
                REG_RECEIVE_DATA_FIFO: begin
                    s_nxt.rdata = s_r.fifo[0].data;
                    pop = (s_r.count != '0);
                end
                default: s_nxt.rdata = 8'h00;
            endcase
        end
        // transfer from shift register, blocked by overrun
        push = accept && !s_r.overrun_error && ((s_r.count < CNT_W'(DEPTH)) || pop);
        overrun = accept && !s_r.overrun_error && !push;
        widx = pop ? CNT_W'(s_r.count - 1'b1) : s_r.count;
        if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                s_nxt.fifo[i] = s_r.fifo[i+1];  // next entry moves up
            end
        end
        if (push) s_nxt.fifo[widx] = fr.word;
        s_nxt.count = CNT_W'(s_r.count + CNT_W'(push) - CNT_W'(pop));
        // flag follows occupancy, so a push beats a draining read
        s_nxt.receive_flag = (s_nxt.count != '0);
        if (overrun) s_nxt.overrun_error = 1'b1;
        if (!s_r.continuous_receive_enable) s_nxt.overrun_error = 1'b0;
        s_nxt.irq = s_nxt.receive_flag & s_nxt.peripheral_irq_enables[RECEIVE_IRQ_ENABLE_BIT]
                  & s_nxt.interrupt_control[GLOBAL_IRQ_ENABLE_BIT]
                  & s_nxt.interrupt_control[PERIPHERAL_IRQ_ENABLE_BIT];
    end

    // ============================================================
    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
            s_r.awready <= 1'b1;
            s_r.wready <= 1'b1;
            s_r.arready <= 1'b1;
            s_r.interrupt_control <= INTERRUPT_CONTROL_RESET;
            s_r.peripheral_irq_enables <= PERIPHERAL_IRQ_ENABLES_RESET;
            s_r.transmit_status_control <= TRANSMIT_STATUS_CONTROL_RESET;
            s_r.baud_divisor <= BAUD_DIVISOR_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state register
    assign s_axi_awready = s_r.awready;
    assign s_axi_wready = s_r.wready;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_arready = s_r.arready;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rresp = s_r.rresp;
    assign s_axi_rdata = {24'h000000, s_r.rdata};
    assign rx_irq = s_r.irq;

    // ============================================================
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_last_pop;
        pop && (s_r.count == CNT_W'(1)) && !push;
    endsequence
    sequence s_full_pop;
        pop && (s_r.count == CNT_W'(DEPTH));
    endsequence
    property p_flag_set;
        push |=> s_r.receive_flag ##1 (s_r.receive_flag || $past(pop));
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");
    property p_irq_gate;
        s_r.irq |-> s_r.receive_flag && s_r.peripheral_irq_enables[RECEIVE_IRQ_ENABLE_BIT];
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");
    property p_flag_clear;
        s_last_pop |=> !s_r.receive_flag && (s_r.count == '0);
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");
    property p_depth;
        s_r.count <= CNT_W'(DEPTH);
    endproperty
    a_depth: assert property (p_depth) else $error("fifo overfilled");
    property p_overrun;
        overrun |=> s_r.overrun_error && (s_r.count == CNT_W'(DEPTH));
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged");
    property p_overrun_error_life;
        s_r.overrun_error && s_r.continuous_receive_enable |=> s_r.overrun_error;
    endproperty
    a_overrun_error_life: assert property (p_overrun_error_life) else $error("overrun lost");
    property p_block;
        s_r.overrun_error |-> !push;
    endproperty
    a_block: assert property (p_block) else $error("push during overrun");
    property p_addr_filter;
        fr.done && s_r.nine_bit_receive && s_r.address_detect_enable && !fr.word.bit9
            |-> !push;
    endproperty
    a_addr_filter: assert property (p_addr_filter) else $error("data word loaded");
    property p_advance;
        s_full_pop |=> s_r.fifo[0] == $past(s_r.fifo[1]);
    endproperty
    a_advance: assert property (p_advance) else $error("fifo order broken");
endmodule : asr_receiver
`default_nettype wire

// ### asr_tx_model.sv
// remote serial transmitter driving the receive line
`default_nettype none
module asr_tx_model #(parameter int BIT = 16) (
    // clock
    input wire logic aclk,
    // frame request
    input wire logic go,
    input wire logic [8:0] word,
    input wire logic nine,
    input wire logic bad_stop,
    // serial line
    output logic tx_line,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [10:0] sh;
    int n;
    int c;
    // ============================================================
    // line idles high; start low, lsb-first data, one stop bit, no parity
    initial begin
        tx_line = 1'b1;
        busy = 1'b0;
    end
    always @(posedge aclk) begin
        if (!busy && go) begin
            sh <= nine ? {!bad_stop, word, 1'b0} : {1'b1, !bad_stop, word[7:0], 1'b0};
            tx_line <= 1'b0;
            n <= nine ? 10 : 9;
            c <= 0;
            busy <= 1'b1;
        end else if (busy) begin
            c <= (c == BIT - 1) ? 0 : c + 1;
            if (c == BIT - 1) begin
                tx_line <= (n == 0) ? 1'b1 : sh[1];
                sh <= sh >> 1;
                n <= n - 1;
                busy <= (n != 0);
            end
        end
    end
endmodule : asr_tx_model
`default_nettype wire

// ### testbench.sv
// self-checking bench of the asynchronous serial receiver
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module testbench import asr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk, aresetn, awvalid, wvalid, arvalid, go, nine, bad, line, busy, sleep;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [8:0] word;
    logic [7:0] b0, b1;
    logic [9:0] exq[$];
    logic [9:0] exp_w;
    int mismatches, checks;
    // ============================================================
    // design, far-side transmitter, clock
    asr_receiver dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(1'b1), .rx_line(line), .sleep_mode(sleep), .rx_irq(irq));
    asr_tx_model tx (.aclk(aclk), .go(go), .word(word), .nine(nine), .bad_stop(bad),
        .tx_line(line), .busy(busy));
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    // ============================================================
    // verdict, bus and frame tasks
    task automatic stop_test(input logic tmo);
        if (tmo) mismatches++;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    task automatic wr(input logic [9:0] i, input logic [7:0] d);
        int k;
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid} <= {i, 2'b00, 24'h0, d, 2'b11};
        exq.push_back({RESP_OKAY, 8'h00});
        for (k = 0; k < 200 && !bvalid; k++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        if (k == 200) stop_test(1'b1);
    endtask : wr
    task automatic rd(input logic [9:0] i, input logic [1:0] r, input logic [7:0] d);
        int k;
        @(posedge aclk);
        {araddr, arvalid} <= {i, 2'b00, 1'b1};
        exq.push_back({r, d});
        for (k = 0; k < 200 && !rvalid; k++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end
        if (k == 200) stop_test(1'b1);
    endtask : rd
    task automatic send(input logic [8:0] w, input logic n9, input logic bs);
        int k;
        @(posedge aclk);
        {word, nine, bad, go} <= {w, n9, bs, 1'b1};
        @(posedge aclk);
        go <= 1'b0;
        for (k = 0; k < 400 && (k == 0 || busy); k++) @(posedge aclk);
        if (k == 400) stop_test(1'b1);
        repeat (4) @(posedge aclk);
    endtask : send
    // ============================================================
    // response watcher: oldest expectation against each bus answer
    always @(posedge aclk) begin
        if ((bvalid || rvalid) && exq.size() > 0) exp_w = exq.pop_front();
        if (bvalid) `CHK({bresp, 8'h00}, exp_w)
        if (rvalid) `CHK({rresp, rdata[7:0]}, exp_w)
    end
    // ============================================================
    // main sequence
    initial begin
        void'($urandom(46213));
        {aresetn, awvalid, wvalid, arvalid, go, nine, bad, sleep} = 8'h00;
        {awaddr, araddr, wdata, word} = '0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rd(REG_TRANSMIT_STATUS_CONTROL, RESP_OKAY, 8'h02);
        rd(10'h3ff, RESP_SLVERR, 8'h00);
        wr(REG_BAUD_DIVISOR, 8'h00);
        wr(REG_TRANSMIT_STATUS_CONTROL, 8'h04);
        wr(REG_PERIPHERAL_IRQ_ENABLES, 8'h20);
        wr(REG_INTERRUPT_CONTROL, 8'hc0);
        wr(REG_RECEIVE_STATUS_CONTROL, 8'h90);
        b0 = 8'($urandom);
        b1 = 8'($urandom);
        // two back-to-back words, a third into a full queue, a fourth while overrun blocks
        for (int p = 0; p < 2; p++) begin
            send({1'b0, b0}, 1'b0, 1'b0);
            send({1'b0, b1}, 1'b0, 1'b0);
            if (p == 0) `CHK(irq, 1'b1)
            if (p == 0) rd(REG_PERIPHERAL_FLAGS, RESP_OKAY, 8'h20);
            if (p == 1) send(9'h0a5, 1'b0, 1'b0);
            if (p == 1) rd(REG_RECEIVE_STATUS_CONTROL, RESP_OKAY, 8'h92);
            rd(REG_RECEIVE_DATA_FIFO, RESP_OKAY, b0);
            if (p == 1) send(9'h05a, 1'b0, 1'b0);
            rd(REG_RECEIVE_DATA_FIFO, RESP_OKAY, b1);
            rd(REG_PERIPHERAL_FLAGS, RESP_OKAY, 8'h00);
        end
        wr(REG_RECEIVE_STATUS_CONTROL, 8'h80);
        wr(REG_RECEIVE_STATUS_CONTROL, 8'h90);
        rd(REG_RECEIVE_STATUS_CONTROL, RESP_OKAY, 8'h90);
        send({1'b0, b1}, 1'b0, 1'b1);
        rd(REG_RECEIVE_STATUS_CONTROL, RESP_OKAY, 8'h94);
        rd(REG_RECEIVE_DATA_FIFO, RESP_OKAY, b1);
        // nine-bit address detect: only the word with ninth bit set lands
        wr(REG_RECEIVE_STATUS_CONTROL, 8'h80);
        wr(REG_RECEIVE_STATUS_CONTROL, 8'hd8);
        send({1'b0, b1}, 1'b1, 1'b0);
        send({1'b1, b0}, 1'b1, 1'b0);
        rd(REG_RECEIVE_STATUS_CONTROL, RESP_OKAY, 8'hd9);
        rd(REG_RECEIVE_DATA_FIFO, RESP_OKAY, b0);
        // sleeping device ignores a valid frame
        sleep <= 1'b1;
        send({1'b1, b1}, 1'b1, 1'b0);
        sleep <= 1'b0;
        rd(REG_PERIPHERAL_FLAGS, RESP_OKAY, 8'h00);
        // clocked-mode select set: the asynchronous receiver stays idle
        wr(REG_TRANSMIT_STATUS_CONTROL, 8'h14);
        rd(REG_TRANSMIT_STATUS_CONTROL, RESP_OKAY, 8'h16);
        send({1'b1, b1}, 1'b1, 1'b0);
        rd(REG_PERIPHERAL_FLAGS, RESP_OKAY, 8'h00);
        stop_test(1'b0);
    end
endmodule : testbench
`default_nettype wire
